/* File: design/gog_pkg.sv */
// Shared constants for the option-board glue and its host end
package gog_pkg;
  // Clock rates and derived cycle counts
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned E_CLK_HZ     = 921_600;
  localparam int unsigned E_HALF_CYC   = CLK_HZ / (2 * E_CLK_HZ);
  localparam int unsigned PWR_WAIT_US  = 1000;
  localparam int unsigned PWR_WAIT_CYC = (CLK_HZ / 1_000_000) * PWR_WAIT_US;
  // Option address window, upper thirteen bits
  localparam logic [15:0] OPT_BASE     = 16'h0028;
  localparam logic [15:0] OPT_LAST     = 16'h002F;
  localparam logic [12:0] OPT_ADDR_HI  = OPT_BASE[15:3];
  localparam int unsigned INIT_WRITES  = 6;
  // Host register offsets
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_CMD      = 8'h08;
  localparam logic [7:0]  REG_RDATA    = 8'h0C;
  localparam logic [7:0]  REG_INIT_LO  = 8'h10;
  localparam logic [7:0]  REG_INIT_HI  = 8'h14;
  // Field positions
  localparam int unsigned CTRL_PWR_BIT = 0;
  localparam int unsigned CTRL_RST_BIT = 1;
  localparam int unsigned CMD_RNW_BIT  = 8;
  localparam int unsigned CMD_DAT_LSB  = 16;
  // Reset values and AXI response codes
  localparam logic [1:0]  CTRL_RESET   = 2'h2;
  localparam logic [31:0] INIT_RESET   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : gog_pkg

/* File: design/gog_bus_if.sv */
// Host microprocessor bus between main board and option board
interface gog_bus_if;
  logic [15:0] host_addr;            // Full host address
  logic        host_rnw;             // High on read cycle
  logic        host_rd_n;            // Read strobe
  logic        host_wr_n;            // Write strobe
  logic        host_e_clk;           // Host phase clock
  logic        sys_reset;            // System reset, active high
  logic        option_power_switch_n;
  logic [7:0]  host_data_o;
  logic        host_data_oe;
  logic [7:0]  opt_data_o;
  logic        opt_data_oe;
  logic        option_sense;         // Option ties low when fitted
  logic        irq_o;
  logic        irq_oe;
  logic [7:0]  data_wire;
  logic        host_interrupt_n;

  // Wire resolution; pull-up holds interrupt high when undriven
  assign data_wire = opt_data_oe ? opt_data_o :
                     (host_data_oe ? host_data_o : 8'hFF);
  assign host_interrupt_n = irq_oe ? irq_o : 1'b1;

  modport host_mp (
    output host_addr, host_rnw, host_rd_n, host_wr_n, host_e_clk,
    output sys_reset, option_power_switch_n, host_data_o, host_data_oe,
    input  data_wire, option_sense, host_interrupt_n
  );
  modport option_mp (
    input  host_addr, host_rnw, host_rd_n, host_wr_n, host_e_clk,
    input  sys_reset, option_power_switch_n, data_wire,
    output opt_data_o, opt_data_oe, option_sense, irq_o, irq_oe
  );
endinterface : gog_bus_if

/* File: design/gog_sync2.sv */
// Two-flop level synchroniser for pins from outside the clock domain
module gog_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // A zero-width synchroniser has nothing to carry
  if (WIDTH < 1)
  begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  // Only the second stage is read outside this module
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : gog_sync2

/* File: design/gog_option_end.sv */
// Option-board glue: decode, isolation, reset and transceiver direction
module gog_option_end
  import gog_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  gog_bus_if.option_mp    bus,
  // Controller chip side
  output logic [2:0]      ctl_addr,
  output logic            ctl_rd_n,
  output logic            ctl_we_n,
  output logic            ctl_e_clk,
  output logic            ctl_ce_n,
  output logic            ctl_buf_oe,
  output logic            ctl_data_bus_in_enable,
  output logic            ctl_reset_n,
  output logic [7:0]      ctl_data_o,
  output logic            ctl_data_oe,
  input  wire logic [7:0] ctl_data_i,
  input  wire logic       ctl_irq_n,
  input  wire logic       talker_direction,
  output logic            ctl_in_charge,
  // Bus transceiver direction, high means transmit
  input  wire logic       gpib_atn_in,
  output logic            dio_tx,
  output logic            dav_tx,
  output logic            nrfd_tx,
  output logic            ndac_tx,
  output logic            srq_tx,
  output logic            atn_tx,
  output logic            ifc_tx,
  output logic            ren_tx,
  output logic            eoi_tx
);
  logic       power_on;
  logic       strobe;
  logic       opt_cs;
  logic       cs_prev_r;
  logic       rst_ff_r;
  logic [7:0] host_rdata_r;
  logic [7:0] ctl_wdata_r;
  logic [2:0] pin_sync;
  logic       irq_n_s;
  logic       talk_s;
  logic       atn_s;
  logic       dir_talk_r;
  logic       dir_eoi_r;

  // Controller pins come from its own logic, not this clock
  gog_sync2 #(
    .WIDTH    (3)
  ) u_pin_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({ctl_irq_n, talker_direction, gpib_atn_in}),
    .sync_out (pin_sync)
  );
  assign irq_n_s = pin_sync[2];
  assign talk_s  = pin_sync[1];
  assign atn_s   = pin_sync[0];

  // Option grounds the sense line; host pulls it up
  assign bus.option_sense = 1'b0;

  // Power switch control is active low
  assign power_on = ~bus.option_power_switch_n;
  assign strobe   = ~bus.host_rd_n | ~bus.host_wr_n;

  // Window decode on the thirteen upper bits, gated by power
  assign opt_cs = power_on && strobe &&
                  (bus.host_addr[15:3] == OPT_ADDR_HI);

  // Buffered copies toward the controller; isolated when unpowered
  assign ctl_buf_oe = power_on;
  assign ctl_addr   = bus.host_addr[2:0];
  assign ctl_rd_n   = bus.host_rd_n;
  assign ctl_e_clk  = bus.host_e_clk;
  assign ctl_ce_n   = ~opt_cs;
  assign ctl_data_bus_in_enable   = opt_cs & bus.host_rnw;
  // Rising edge of this strobe latches host data in the controller
  assign ctl_we_n   = ~(opt_cs & ~bus.host_rnw & ~bus.host_wr_n);

  // Previous select level, to find the end of the select pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cs_prev_r <= 1'b0;
    else
      cs_prev_r <= opt_cs;
  end

  // Reset flip-flop: cleared by sysreset or power off, set at select end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rst_ff_r <= 1'b0;
    else if (bus.sys_reset || !power_on)
      rst_ff_r <= 1'b0;
    else if (cs_prev_r && !opt_cs)
      rst_ff_r <= 1'b1;
  end

  // Gate again so a clear acts in the same cycle, not one late
  assign ctl_reset_n = rst_ff_r & power_on & ~bus.sys_reset;

  // Transceiver data paths, one register stage each way
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rdata_r <= 8'h00;
      ctl_wdata_r  <= 8'h00;
    end
    else
    begin
      host_rdata_r <= ctl_data_i;
      ctl_wdata_r  <= bus.data_wire;
    end
  end

  // Transceiver enabled only inside a decoded cycle
  assign bus.opt_data_o  = host_rdata_r;
  assign bus.opt_data_oe = opt_cs & bus.host_rnw;
  assign ctl_data_o      = ctl_wdata_r;
  assign ctl_data_oe     = opt_cs & ~bus.host_rnw;

  // Interrupt buffer drives both levels when powered
  assign bus.irq_o  = irq_n_s;
  assign bus.irq_oe = power_on;

  // Talker-driven direction, registered to avoid glitches on pins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_talk_r <= 1'b0;
      dir_eoi_r  <= 1'b0;
    end
    else
    begin
      dir_talk_r <= talk_s;
      dir_eoi_r  <= talk_s & atn_s;
    end
  end

  // Fixed directions except EOI, which follows talker and ATN: this board is always controller-in-charge side
  assign ctl_in_charge = 1'b1;
  assign srq_tx        = 1'b1;
  assign atn_tx        = 1'b0;
  assign ifc_tx        = 1'b0;
  assign ren_tx        = 1'b0;
  assign eoi_tx        = dir_eoi_r;

  // Data and DAV with the talker, handshake lines opposite
  assign dio_tx  = dir_talk_r;
  assign dav_tx  = dir_talk_r;
  assign nrfd_tx = ~dir_talk_r;
  assign ndac_tx = ~dir_talk_r;
endmodule : gog_option_end

/* File: design/gog_host_end.sv */
// Host end: AXI4-Lite registers, power control and bus cycle engine
module gog_host_end
  import gog_pkg::*;
#(
  parameter int unsigned PWR_WAIT = PWR_WAIT_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  gog_bus_if.host_mp       bus,
  input  wire logic        ac_power_present_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [2:0] {S_OFF, S_WAIT, S_WAKE, S_DUMMY, S_INIT,
                            S_READY} gog_seq_e;
  typedef enum logic [1:0] {B_IDLE, B_ADDR, B_STRB} gog_bus_e;

  // Wait counter is 24 bits wide
  if (PWR_WAIT < 1 || PWR_WAIT > 32'h00FF_FFFF)
  begin : g_bad_wait
    $error("PWR_WAIT out of range");
  end

  gog_seq_e    seq_r;
  gog_bus_e    bst_r;
  logic [23:0] wait_r;
  logic [2:0]  init_idx_r;
  logic [1:0]  ctrl_r;
  logic [31:0] init_lo_r, init_hi_r;
  logic        aw_got_r, w_got_r, wstrb0_r;
  logic [7:0]  aw_off_r;
  logic [31:0] wdata_r;
  logic        cmd_pend_r;
  logic [2:0]  cmd_reg_r;
  logic        cmd_rnw_r;
  logic [7:0]  cmd_dat_r, rdata8_r;
  logic [4:0]  ediv_r;
  logic        e_r, e_rise, e_fall;
  logic        ac_n_s, allowed, bus_go, bus_done;
  logic [2:0]  go_reg;
  logic        go_rnw;
  logic [7:0]  go_dat;
  logic        wr_fire, map_ok;
  logic [7:0]  ar_off;

  gog_sync2 #(
    .WIDTH    (1)
  ) u_ac_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (ac_power_present_n),
    .sync_out (ac_n_s)
  );

  // Power only with option fitted and line power present
  assign allowed = ctrl_r[CTRL_PWR_BIT] & ~ac_n_s & ~bus.option_sense;
  assign bus.option_power_switch_n = ~allowed;
  assign bus.sys_reset = ctrl_r[CTRL_RST_BIT];

  // Phase clock divider with edge enables
  assign e_rise = (ediv_r == 5'(E_HALF_CYC - 1)) & ~e_r;
  assign e_fall = (ediv_r == 5'(E_HALF_CYC - 1)) & e_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ediv_r <= 5'h00;
      e_r    <= 1'b0;
    end
    else if (ediv_r == 5'(E_HALF_CYC - 1))
    begin
      ediv_r <= 5'h00;
      e_r    <= ~e_r;
    end
    else
      ediv_r <= ediv_r + 5'h01;
  end
  assign bus.host_e_clk = e_r;

  // Cycle source: start-up sequence first, then software commands
  always_comb
  begin
    go_reg = cmd_reg_r;
    go_rnw = cmd_rnw_r;
    go_dat = cmd_dat_r;
    bus_go = 1'b0;
    if (bst_r == B_IDLE && allowed)
    begin
      unique case (seq_r)
        S_WAKE, S_DUMMY:
        begin
          go_reg = 3'h0;
          go_rnw = 1'b1;
          bus_go = 1'b1;
        end
        S_INIT:
        begin
          go_reg = init_idx_r;
          go_rnw = 1'b0;
          go_dat = init_idx_r[2] ? init_hi_r[8*init_idx_r[0] +: 8]
                                 : init_lo_r[8*init_idx_r[1:0] +: 8];
          bus_go = 1'b1;
        end
        S_READY: bus_go = cmd_pend_r;
        S_OFF, S_WAIT: bus_go = 1'b0;
      endcase
    end
  end
  assign bus_done = (bst_r == B_STRB) & e_fall;

  // Bus engine: address as soon as a cycle starts, strobe through E high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bst_r            <= B_IDLE;
      bus.host_addr    <= 16'h0000;
      bus.host_rnw     <= 1'b1;
      bus.host_rd_n    <= 1'b1;
      bus.host_wr_n    <= 1'b1;
      bus.host_data_o  <= 8'h00;
      bus.host_data_oe <= 1'b0;
      rdata8_r         <= 8'h00;
    end
    else if (!allowed)
    begin
      bst_r            <= B_IDLE;
      bus.host_rd_n    <= 1'b1;
      bus.host_wr_n    <= 1'b1;
      bus.host_data_oe <= 1'b0;
    end
    else
    begin
      unique case (bst_r)
        B_IDLE:
          if (bus_go)
          begin
            bst_r            <= B_ADDR;
            bus.host_addr    <= {OPT_ADDR_HI, go_reg};
            bus.host_rnw     <= go_rnw;
            bus.host_data_o  <= go_dat;
            bus.host_data_oe <= ~go_rnw;
          end
        B_ADDR:
          if (e_rise)
          begin
            bst_r         <= B_STRB;
            bus.host_rd_n <= ~bus.host_rnw;
            bus.host_wr_n <= bus.host_rnw;
          end
        B_STRB:
          if (e_fall)
          begin
            bst_r            <= B_IDLE;
            bus.host_rd_n    <= 1'b1;
            bus.host_wr_n    <= 1'b1;
            bus.host_data_oe <= 1'b0;
            if (bus.host_rnw)
              rdata8_r <= bus.data_wire;
          end
      endcase
    end
  end

  // Start-up: wait, wake cycle, dummy read, six init writes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_r      <= S_OFF;
      wait_r     <= 24'h000000;
      init_idx_r <= 3'h0;
    end
    else if (!allowed)
      seq_r <= S_OFF;
    else
    begin
      unique case (seq_r)
        S_OFF:
        begin
          seq_r  <= S_WAIT;
          wait_r <= 24'h000000;
        end
        S_WAIT:
          if (wait_r == 24'(PWR_WAIT - 1))
            seq_r <= S_WAKE;
          else
            wait_r <= wait_r + 24'h000001;
        S_WAKE:
          if (bus_done)
            seq_r <= S_DUMMY;
        S_DUMMY:
          if (bus_done)
          begin
            seq_r      <= S_INIT;
            init_idx_r <= 3'h0;
          end
        S_INIT:
          if (bus_done)
          begin
            if (init_idx_r == 3'(INIT_WRITES - 1))
              seq_r <= S_READY;
            init_idx_r <= init_idx_r + 3'h1;
          end
        S_READY: seq_r <= S_READY;
      endcase
    end
  end

  // AXI write: address and data taken in either order
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
  assign wr_fire       = aw_got_r & w_got_r & ~s_axi_bvalid;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_off_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb0_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_off_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        // Strobe kept with its data; the bus may move on
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign map_ok = (aw_off_r == REG_CTRL) || (aw_off_r == REG_CMD) ||
                  (aw_off_r == REG_INIT_LO) || (aw_off_r == REG_INIT_HI) ||
                  (aw_off_r == REG_STATUS) || (aw_off_r == REG_RDATA);

  // Writable registers; a command while one is pending is dropped
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r     <= CTRL_RESET;
      init_lo_r  <= INIT_RESET;
      init_hi_r  <= INIT_RESET;
      cmd_pend_r <= 1'b0;
      cmd_reg_r  <= 3'h0;
      cmd_rnw_r  <= 1'b1;
      cmd_dat_r  <= 8'h00;
    end
    else
    begin
      if (seq_r == S_READY && bst_r == B_IDLE && bus_go)
        cmd_pend_r <= 1'b0;
      else if (!allowed)
        cmd_pend_r <= 1'b0;
      if (wr_fire && wstrb0_r && aw_off_r == REG_CTRL)
        ctrl_r <= wdata_r[1:0];
      if (wr_fire && aw_off_r == REG_INIT_LO)
        init_lo_r <= wdata_r;
      if (wr_fire && aw_off_r == REG_INIT_HI)
        init_hi_r <= {16'h0000, wdata_r[15:0]};
      if (wr_fire && aw_off_r == REG_CMD && !cmd_pend_r &&
          seq_r == S_READY)
      begin
        cmd_pend_r <= 1'b1;
        cmd_reg_r  <= wdata_r[2:0];
        cmd_rnw_r  <= wdata_r[CMD_RNW_BIT];
        cmd_dat_r  <= wdata_r[CMD_DAT_LSB +: 8];
      end
    end
  end

  // AXI read: one-cycle answer held until rready
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_off        = s_axi_araddr[7:0];
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (ar_off)
        REG_CTRL:    s_axi_rdata <= {30'h0, ctrl_r};
        REG_STATUS:  s_axi_rdata <= {24'h0, seq_r,
                                     cmd_pend_r | (bst_r != B_IDLE),
                                     ~bus.host_interrupt_n, allowed,
                                     ~ac_n_s, ~bus.option_sense};
        REG_CMD:     s_axi_rdata <= {8'h0, cmd_dat_r, 7'h0, cmd_rnw_r,
                                     5'h0, cmd_reg_r};
        REG_RDATA:   s_axi_rdata <= {24'h0, rdata8_r};
        REG_INIT_LO: s_axi_rdata <= init_lo_r;
        REG_INIT_HI: s_axi_rdata <= init_hi_r;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule : gog_host_end

/* File: bench/gog_glue_monitor.sv */
// Concurrent checks on the host bus and the option glue outputs
module gog_glue_monitor
  import gog_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [15:0] host_addr,
  input wire logic        host_rnw,
  input wire logic        host_rd_n,
  input wire logic        host_wr_n,
  input wire logic        sys_reset,
  input wire logic        option_power_switch_n,
  input wire logic        opt_data_oe,
  input wire logic        irq_oe,
  input wire logic        host_interrupt_n,
  input wire logic        ctl_ce_n,
  input wire logic        ctl_reset_n,
  input wire logic        ctl_data_bus_in_enable,
  input wire logic        ctl_buf_oe,
  input wire logic        ctl_in_charge,
  input wire logic        host_e_clk,
  input wire logic        ctl_e_clk,
  input wire logic        ctl_rd_n,
  input wire logic        ctl_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Decode window and its cause
  property p_sel_win;
    !ctl_ce_n |-> !option_power_switch_n && host_addr[15:3] == OPT_ADDR_HI;
  endproperty
  a_sel_win: assert property (p_sel_win)
    else $error("select out of window");
  property p_sel_hit;
    !option_power_switch_n && (!host_rd_n || !host_wr_n) &&
      host_addr[15:3] == OPT_ADDR_HI |-> !ctl_ce_n;
  endproperty
  a_sel_hit: assert property (p_sel_hit)
    else $error("select missing");
  // Isolation while unpowered
  property p_off_iso;
    option_power_switch_n |-> ctl_ce_n && !ctl_buf_oe && !irq_oe;
  endproperty
  a_off_iso: assert property (p_off_iso)
    else $error("not isolated");
  property p_irq_pull;
    option_power_switch_n |-> host_interrupt_n;
  endproperty
  a_irq_pull: assert property (p_irq_pull)
    else $error("irq not high");
  // Controller reset sequencing
  property p_rst_hold;
    sys_reset || option_power_switch_n |-> !ctl_reset_n;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset not held");
  property p_rst_keep;
    !ctl_reset_n && !ctl_ce_n |=> !ctl_reset_n;
  endproperty
  a_rst_keep: assert property (p_rst_keep)
    else $error("early release");
  property p_rst_rel;
    $rose(ctl_ce_n) && !option_power_switch_n && !sys_reset
      |-> ##[0:2] ctl_reset_n;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("no release");
  // Data path direction
  property p_data_bus_in_enable;
    ctl_data_bus_in_enable |-> !ctl_ce_n && host_rnw;
  endproperty
  a_data_bus_in_enable: assert property (p_data_bus_in_enable)
    else $error("data-in enable wrong");
  property p_data_dir;
    opt_data_oe |-> !ctl_ce_n && host_rnw;
  endproperty
  a_data_dir: assert property (p_data_dir)
    else $error("bus driven");
  property p_wr_dir;
    ctl_data_oe |-> !ctl_ce_n && !host_rnw;
  endproperty
  a_wr_dir: assert property (p_wr_dir)
    else $error("controller data driven");
  property p_cic;
    ctl_in_charge;
  endproperty
  a_cic: assert property (p_cic)
    else $error("in-charge low");
  // Buffered copies follow the host while powered
  property p_buf_copy;
    ctl_buf_oe |-> ctl_rd_n == host_rd_n && ctl_e_clk == host_e_clk;
  endproperty
  a_buf_copy: assert property (p_buf_copy)
    else $error("buffered copy differs");
  // Phase clock is square: 27 system clocks each half
  property p_eclk_sq;
    $rose(host_e_clk) |-> ctl_e_clk ##27 $fell(ctl_e_clk);
  endproperty
  a_eclk_sq: assert property (p_eclk_sq)
    else $error("phase clock not square");
endmodule : gog_glue_monitor

/* File: bench/gpib_option_host_glue_tb.sv */
// Bench joining host end and option end over one host bus
module gpib_option_host_glue_tb
  import gog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst_n = 1'b0, ac_power_present_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [2:0]  ctl_addr, wa [8];
  logic [7:0]  ctl_data_o, wd [8], ctl_data_i = 8'h5A;
  logic        ctl_irq_n = 1'b1, talker_direction = 1'b0, gpib_atn_in = 1'b0;
  logic        ctl_we_n, ctl_ce_n, ctl_reset_n, ctl_in_charge, ctl_buf_oe;
  logic        ctl_data_bus_in_enable, dio_tx, dav_tx, nrfd_tx, ndac_tx;
  logic        ctl_e_clk, ctl_rd_n, ctl_data_oe;
  logic        srq_tx, atn_tx, ifc_tx, ren_tx, eoi_tx;
  int          error_cnt = 0, n_tests = 0, cyc = 0, nw = 0;

  always #10 clock = ~clock;
  gog_bus_if bus_i ();
  gog_host_end #(.PWR_WAIT(20)) i_gog_host_end (.clock, .rst_n, .bus(bus_i),
    .ac_power_present_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  gog_option_end i_gog_option_end (.clock, .rst_n, .bus(bus_i), .ctl_addr,
    .ctl_rd_n, .ctl_we_n, .ctl_e_clk, .ctl_ce_n, .ctl_buf_oe, .ctl_data_bus_in_enable,
    .ctl_reset_n, .ctl_data_o, .ctl_data_oe, .ctl_data_i, .ctl_irq_n,
    .talker_direction, .ctl_in_charge, .gpib_atn_in, .dio_tx, .dav_tx,
    .nrfd_tx, .ndac_tx, .srq_tx, .atn_tx, .ifc_tx, .ren_tx, .eoi_tx);
  gog_glue_monitor i_mon (.clock, .rst_n, .host_addr(bus_i.host_addr),
    .host_rnw(bus_i.host_rnw), .host_rd_n(bus_i.host_rd_n),
    .host_wr_n(bus_i.host_wr_n), .sys_reset(bus_i.sys_reset),
    .option_power_switch_n(bus_i.option_power_switch_n),
    .opt_data_oe(bus_i.opt_data_oe), .irq_oe(bus_i.irq_oe),
    .host_interrupt_n(bus_i.host_interrupt_n), .ctl_ce_n, .ctl_reset_n,
    .ctl_data_bus_in_enable, .ctl_buf_oe, .ctl_in_charge, .host_e_clk(bus_i.host_e_clk),
    .ctl_e_clk, .ctl_rd_n, .ctl_data_oe);

  // Log controller writes at the latching edge of the strobe
  always @(posedge ctl_we_n)
  begin
    if (rst_n === 1'b1 && nw < 8)
    begin
      wa[nw] = ctl_addr;
      wd[nw] = ctl_data_o;
      nw++;
    end
  end
  // Hang guard, well above the seven hundred or so cycles needed
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Write; each channel released when taken, bready held high
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : axi_rd

  // Poll status until masked bits match, bounded
  task automatic poll(input logic [31:0] m, v);
    for (int i = 0; i < 1000; i++)
    begin
      axi_rd(REG_STATUS);
      if ((rd & m) === v) break;
    end
    chk("status", v, rd & m);
  endtask : poll

  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    axi_rd(REG_STATUS);
    chk("status_idle", 32'h3, rd & 32'hFF);
    chk("reset_off", 1'b0, ctl_reset_n);
    axi_wr(REG_INIT_LO, 32'h4433_2211);
    axi_wr(REG_INIT_HI, 32'h0000_6655);
    axi_wr(REG_CTRL, 32'h1);
    poll(32'hE4, 32'hA4);
    chk("reset_rel", 1'b1, ctl_reset_n);
    chk("init_cnt", 6, nw);
    for (int k = 0; k < 6; k++)
    begin
      chk("init_reg", k, wa[k]);
      chk("init_dat", 8'h11 * (k + 1), wd[k]);
    end
    axi_wr(REG_CMD, 32'h0000_0103);
    poll(32'h10, 32'h0);
    axi_rd(REG_RDATA);
    chk("rd_byte", 8'h5A, rd[7:0]);
    axi_wr(REG_CMD, 32'h00C7_0005);
    poll(32'h10, 32'h0);
    chk("wr_cnt", 7, nw);
    chk("wr_reg", 3'h5, wa[6]);
    chk("wr_dat", 8'hC7, wd[6]);
    axi_rd(8'h40);
    chk("unmapped", RESP_SLVERR, rs);
    // Every talk and attention combination
    for (int t = 0; t < 4; t++)
    begin
      talker_direction <= t[0];
      gpib_atn_in <= t[1];
      repeat (5) @(posedge clock);
      chk("xcvr", {t[0], t[0], ~t[0], ~t[0], 4'h8, t[0] & t[1]},
          {dio_tx, dav_tx, nrfd_tx, ndac_tx, srq_tx, atn_tx, ifc_tx,
           ren_tx, eoi_tx});
    end
    ctl_irq_n <= 1'b0;
    repeat (5) @(posedge clock);
    chk("irq_low", 1'b0, bus_i.host_interrupt_n);
    axi_rd(REG_STATUS);
    chk("irq_stat", 32'h8, rd & 32'h8);
    // System reset alone, option still powered
    axi_wr(REG_CTRL, 32'h3);
    chk("reset_sys", 1'b0, ctl_reset_n);
    axi_wr(REG_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    chk("irq_iso", 1'b1, bus_i.host_interrupt_n);
    chk("reset_pwr", 1'b0, ctl_reset_n);
    // Battery operation: a power request must be refused
    ac_power_present_n <= 1'b1;
    repeat (3) @(posedge clock);
    axi_wr(REG_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    chk("ac_block", 1'b1, bus_i.option_power_switch_n);
    report_and_stop();
  end
endmodule : gpib_option_host_glue_tb
